// *** design/vm2_ctrl.sv ***
// monitor 2 control: apb registers, gating, detection flag, interrupt and reset requests
`timescale 1ns/1ps
module vm2_ctrl
  import vm2_pkg::*;
#(
  parameter int RST_HOLD = VM2_RST_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc,
  input wire logic cmp_above,
  output logic detector_enable,
  output logic [3:0] detect_level_sel,
  output logic irq_maskable,
  output logic irq_nonmaskable,
  output logic monitor_reset_req
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] osc_sync;
    logic osc_prev;
    logic [1:0] cmp_sync;
    logic [3:0] level;
    logic det_en;
    logic rie;
    logic cmpe;
    logic fdis;
    logic [1:0] fsamp;
    logic ri;
    logic rn;
    logic [1:0] idtsel;
    logic irqsel;
    logic flag;
    logic gated_prev;
    logic irq_m;
    logic irq_n;
    logic rst_req;
    logic [15:0] hold_cnt;
    logic [31:0] rdata;
  } vm2_state_s;

  vm2_state_s s_r;
  vm2_state_s s_nxt;
  logic osc_edge;
  logic det_level;
  logic filt_level;
  logic gated;
  logic rise;
  logic fall;
  logic irq_evt;
  logic evt;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd_val;

  if (RST_HOLD < 1 || RST_HOLD > 65535) begin : g_bad_hold
    $error("vm2_ctrl: RST_HOLD must lie in 1..65535");
  end

  // ---------------------------------------------------------------
  // noise filter
  // ---------------------------------------------------------------
  vm2_filter #(
    .AGREE(VM2_FILT_AGREE)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .osc_edge(osc_edge),
    .raw_level(det_level),
    .sample_sel(s_r.fsamp),
    .filter_disable(s_r.fdis),
    .level_out(filt_level)
  );

  // synchronised oscillator edge and comparator level
  assign osc_edge = s_r.osc_sync[1] & ~s_r.osc_prev;
  assign det_level = s_r.det_en ? s_r.cmp_sync[1] : 1'b1; // disabled detector reads above

  // output gate and crossing detection
  assign gated = s_r.cmpe ? filt_level : 1'b1;
  assign rise = gated & ~s_r.gated_prev;
  assign fall = ~gated & s_r.gated_prev;

  // timing select picks which crossing counts in interrupt mode
  always_comb begin
    unique case (s_r.idtsel)
      VM2_IDT_RISE: irq_evt = rise;
      VM2_IDT_FALL: irq_evt = fall;
      VM2_IDT_BOTH: irq_evt = rise | fall;
      default: irq_evt = fall;
    endcase
  end
  assign evt = s_r.ri ? fall : irq_evt;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign mapped = (paddr == VM2_OFS_LEVEL) || (paddr == VM2_OFS_DETCTL) ||
                  (paddr == VM2_OFS_CTRL0) || (paddr == VM2_OFS_CTRL1) ||
                  (paddr == VM2_OFS_STATUS);

  // read view of the registers
  always_comb begin
    rd_val = 32'h0;
    unique case (paddr)
      VM2_OFS_LEVEL: rd_val[VM2_LEVEL_LSB +: 4] = s_r.level;
      VM2_OFS_DETCTL: rd_val[VM2_DETEN_BIT] = s_r.det_en;
      VM2_OFS_CTRL0: begin
        rd_val[VM2_RIE_BIT] = s_r.rie;
        rd_val[VM2_CMPE_BIT] = s_r.cmpe;
        rd_val[VM2_FDIS_BIT] = s_r.fdis;
        rd_val[VM2_FSAMP_LSB +: 2] = s_r.fsamp;
        rd_val[VM2_RI_BIT] = s_r.ri;
        rd_val[VM2_RN_BIT] = s_r.rn;
      end
      VM2_OFS_CTRL1: begin
        rd_val[VM2_IDT_LSB +: 2] = s_r.idtsel;
        rd_val[VM2_IRQSEL_BIT] = s_r.irqsel;
      end
      VM2_OFS_STATUS: begin
        rd_val[VM2_FLAG_BIT] = s_r.flag;
        rd_val[VM2_MON_BIT] = filt_level;
      end
      default: rd_val = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_sync = {s_r.osc_sync[0], low_speed_osc};
    s_nxt.osc_prev = s_r.osc_sync[1];
    s_nxt.cmp_sync = {s_r.cmp_sync[0], cmp_above};
    s_nxt.gated_prev = gated;
    if (psel && !penable) begin
      s_nxt.rdata = rd_val; // captured in setup, shown in access
    end
    // register writes take effect in the access phase
    if (wr) begin
      unique case (paddr)
        VM2_OFS_LEVEL: s_nxt.level = pwdata[VM2_LEVEL_LSB +: 4];
        VM2_OFS_DETCTL: s_nxt.det_en = pwdata[VM2_DETEN_BIT];
        VM2_OFS_CTRL0: begin
          s_nxt.rie = pwdata[VM2_RIE_BIT];
          s_nxt.cmpe = pwdata[VM2_CMPE_BIT];
          s_nxt.fdis = pwdata[VM2_FDIS_BIT];
          s_nxt.fsamp = pwdata[VM2_FSAMP_LSB +: 2];
          s_nxt.ri = pwdata[VM2_RI_BIT];
          s_nxt.rn = pwdata[VM2_RN_BIT];
        end
        VM2_OFS_CTRL1: begin
          s_nxt.idtsel = pwdata[VM2_IDT_LSB +: 2];
          s_nxt.irqsel = pwdata[VM2_IRQSEL_BIT];
        end
        VM2_OFS_STATUS: begin
          if (!pwdata[VM2_FLAG_BIT]) begin
            s_nxt.flag = 1'b0; // writing 1 leaves the flag alone
          end
        end
        default: s_nxt.flag = s_r.flag;
      endcase
    end
    // a detection in the clearing cycle still sets the flag
    if (evt) begin
      s_nxt.flag = 1'b1;
    end
    // one-cycle interrupt pulses of the selected type
    s_nxt.irq_m = evt & s_r.rie & ~s_r.ri & ~s_r.irqsel;
    s_nxt.irq_n = evt & s_r.rie & ~s_r.ri & s_r.irqsel;
    // reset request and its release
    if (!s_r.rie || !s_r.ri) begin
      s_nxt.rst_req = 1'b0;
      s_nxt.hold_cnt = 16'h0;
    end else if (!s_r.rst_req) begin
      if (!gated) begin
        s_nxt.rst_req = 1'b1;
        s_nxt.hold_cnt = 16'h0;
      end
    end else if (!s_r.rn && !gated) begin
      s_nxt.hold_cnt = 16'h0; // release counted from recovery
    end else if (s_r.hold_cnt >= 16'(RST_HOLD - 1)) begin
      s_nxt.rst_req = 1'b0;
      s_nxt.hold_cnt = 16'h0;
    end else begin
      s_nxt.hold_cnt = s_r.hold_cnt + 16'h1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{osc_sync: 2'h0, osc_prev: 1'b0, cmp_sync: 2'h3, level: VM2_LEVEL_RST,
               det_en: 1'b0, rie: 1'b0, cmpe: 1'b0, fdis: VM2_FDIS_RST, fsamp: 2'h0,
               ri: 1'b0, rn: 1'b0, idtsel: VM2_IDT_RISE, irqsel: 1'b0, flag: 1'b0,
               gated_prev: 1'b1, irq_m: 1'b0, irq_n: 1'b0, rst_req: 1'b0,
               hold_cnt: 16'h0, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc & ~mapped;
  assign prdata = s_r.rdata;
  assign detector_enable = s_r.det_en;
  assign detect_level_sel = s_r.level;
  assign irq_maskable = s_r.irq_m;
  assign irq_nonmaskable = s_r.irq_n;
  assign monitor_reset_req = s_r.rst_req;

endmodule : vm2_ctrl

// *** design/vm2_pkg.sv ***
// constants shared by the monitor 2 control block and its noise filter
package vm2_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] VM2_OFS_LEVEL = 8'h00; // detect_level_reg
  localparam logic [7:0] VM2_OFS_DETCTL = 8'h04; // detector_ctrl_reg
  localparam logic [7:0] VM2_OFS_CTRL0 = 8'h08; // monitor_ctrl0
  localparam logic [7:0] VM2_OFS_CTRL1 = 8'h0c; // monitor_ctrl1
  localparam logic [7:0] VM2_OFS_STATUS = 8'h10; // monitor_status_reg

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int VM2_LEVEL_LSB = 0; // detect_level_sel [3:0]
  localparam int VM2_DETEN_BIT = 0; // detector_enable
  localparam int VM2_RIE_BIT = 0; // irq_or_reset_enable
  localparam int VM2_CMPE_BIT = 2; // compare_out_enable
  localparam int VM2_FDIS_BIT = 3; // filter_disable
  localparam int VM2_FSAMP_LSB = 4; // filter_sample_sel [5:4]
  localparam int VM2_RI_BIT = 6; // action_select
  localparam int VM2_RN_BIT = 7; // reset_release_sel
  localparam int VM2_IDT_LSB = 0; // irq_timing_sel [1:0]
  localparam int VM2_IRQSEL_BIT = 2; // irq_type_sel
  localparam int VM2_FLAG_BIT = 0; // detect_flag
  localparam int VM2_MON_BIT = 1; // filtered monitor level, read only

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] VM2_LEVEL_RST = 4'h0;
  localparam logic VM2_FDIS_RST = 1'b1; // filter bypassed out of reset
  localparam logic [1:0] VM2_IDT_RISE = 2'h0; // voltage rises above level
  localparam logic [1:0] VM2_IDT_FALL = 2'h1; // voltage drops below level
  localparam logic [1:0] VM2_IDT_BOTH = 2'h2; // either crossing

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam int VM2_FILT_AGREE = 3; // equal samples before the filter moves
  localparam int VM2_RST_HOLD_CYC = 16; // reset stretch in pclk cycles

endpackage : vm2_pkg

// *** design/vm2_filter.sv ***
// sampling divider and majority-free noise filter for the monitor 2 result
`timescale 1ns/1ps
module vm2_filter
  import vm2_pkg::*;
#(
  parameter int AGREE = VM2_FILT_AGREE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_edge,
  input wire logic raw_level,
  input wire logic [1:0] sample_sel,
  input wire logic filter_disable,
  output logic level_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] div_cnt;
    logic [AGREE-1:0] samples;
    logic level;
  } vm2_filt_s;

  vm2_filt_s s_r;
  vm2_filt_s s_nxt;
  logic [3:0] div_last;
  logic [AGREE-1:0] shifted;

  if (AGREE < 2) begin : g_bad_agree
    $error("vm2_filter: AGREE must be at least 2");
  end

  // divide the oscillator by 2, 4, 8 or 16 and filter on each sample tick
  always_comb begin
    s_nxt = s_r;
    div_last = 4'((5'h2 << sample_sel) - 5'h1);
    shifted = {s_r.samples[AGREE-2:0], raw_level};
    if (filter_disable) begin
      s_nxt.div_cnt = 4'h0; // divider parked while bypassed
      s_nxt.samples = {AGREE{raw_level}};
      s_nxt.level = raw_level;
    end else if (osc_edge) begin
      if (s_r.div_cnt >= div_last) begin
        s_nxt.div_cnt = 4'h0;
        s_nxt.samples = shifted;
        if (&shifted) begin
          s_nxt.level = 1'b1;
        end else if (~|shifted) begin
          s_nxt.level = 1'b0;
        end
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 4'h1;
      end
    end
  end

  // state register; level starts high (voltage above threshold)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{div_cnt: 4'h0, samples: {AGREE{1'b1}}, level: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.level;

endmodule : vm2_filter

// *** verification/vm2_ctrl_props.sv ***
// concurrent checks on the monitor 2 control block ports
`timescale 1ns/1ps
module vm2_ctrl_props
  import vm2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_speed_osc,
  input wire logic cmp_above,
  input wire logic detector_enable,
  input wire logic [3:0] detect_level_sel,
  input wire logic irq_maskable,
  input wire logic irq_nonmaskable,
  input wire logic monitor_reset_req
);
  // ---------------------------------------------------------------
  // shadow of the control words as software wrote them
  // ---------------------------------------------------------------
  logic [7:0] c0_r;
  logic [2:0] c1_r;
  // captures completed apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_r <= 8'h08;
      c1_r <= 3'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == VM2_OFS_CTRL0) c0_r <= pwdata[7:0];
      if (paddr == VM2_OFS_CTRL1) c1_r <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_irq;
    irq_maskable || irq_nonmaskable;
  endsequence
  sequence s_disarm;
    !c0_r[0] || !c0_r[6];
  endsequence
  // requests are registered, so they answer the shadow as it stood one edge earlier
  property p_irq_route; s_irq |-> !$past(c0_r[6]); endproperty
  a_irq_route: assert property (p_irq_route) else $error("irq in reset mode");
  property p_irq_gate; s_irq |-> $past(c0_r[0]); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  property p_rst_arm;
    $rose(monitor_reset_req) |-> $past(c0_r[0]) && $past(c0_r[6]);
  endproperty
  a_rst_arm: assert property (p_rst_arm) else $error("reset not armed");
  property p_irq_type;
    s_irq |-> irq_nonmaskable == $past(c1_r[2]) && !(irq_maskable && irq_nonmaskable);
  endproperty
  a_irq_type: assert property (p_irq_type) else $error("wrong irq kind");
  property p_irq_pulse; s_irq |=> !irq_maskable && !irq_nonmaskable; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_release; s_disarm |=> !monitor_reset_req; endproperty
  a_release: assert property (p_release) else $error("reset kept");
  property p_out_gate;
    !$past(c0_r[2]) && !$past(c0_r[2], 2) |-> !irq_maskable && !irq_nonmaskable;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("irq with output off");
  property p_level; s_wr(VM2_OFS_LEVEL) |=> detect_level_sel == $past(pwdata[3:0]); endproperty
  a_level: assert property (p_level) else $error("level not taken");
  property p_det_en;
    s_wr(VM2_OFS_DETCTL) |=> detector_enable == $past(pwdata[0]);
  endproperty
  a_det_en: assert property (p_det_en) else $error("enable not taken");
endmodule : vm2_ctrl_props

// *** verification/vm2_ctrl_tb_top.sv ***
// self-checking bench for the monitor 2 control block
`timescale 1ns/1ps
module vm2_ctrl_tb_top
  import vm2_pkg::*;
;
  localparam int RH = 4;
  localparam int OSC = 6;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} vm2_row_s;
  logic pclk, presetn, psel, penable, pwrite, low_speed_osc, cmp_above, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, detector_enable, irq_maskable, irq_nonmaskable, monitor_reset_req;
  logic [3:0] detect_level_sel;
  logic [2:0] s;
  int failures = 0;
  int check_count = 0;
  int oc = 0;
  vm2_row_s rows [10] = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h0},
    '{8'h08, 1'b0, 32'h0, 32'h8}, '{8'h0c, 1'b0, 32'h0, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h2},
    '{8'h00, 1'b1, 32'hffffffff, 32'hf}, '{8'h04, 1'b1, 32'hffffffff, 32'h1},
    '{8'h0c, 1'b1, 32'hffffffff, 32'h7}, '{8'h08, 1'b1, 32'hff, 32'hfd},
    '{8'h14, 1'b1, 32'hffffffff, 32'h0}};

  vm2_ctrl #(.RST_HOLD(RH)) vm2_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_osc(low_speed_osc), .cmp_above(cmp_above),
    .detector_enable(detector_enable), .detect_level_sel(detect_level_sel),
    .irq_maskable(irq_maskable), .irq_nonmaskable(irq_nonmaskable),
    .monitor_reset_req(monitor_reset_req));

  // clock and slow oscillator
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    oc <= (oc == 2) ? 0 : oc + 1;
    if (oc == 2) low_speed_osc <= ~low_speed_osc;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // mode first, then flag clear, then gate enable, output last
  task automatic arm(input logic [31:0] c0);
    apb(VM2_OFS_CTRL0, 1'b1, c0 & 32'hfa);
    apb(VM2_OFS_STATUS, 1'b1, 32'h0);
    apb(VM2_OFS_CTRL0, 1'b1, c0 & 32'hfb);
    apb(VM2_OFS_CTRL0, 1'b1, c0);
  endtask : arm
  task automatic lvl(input logic v);
    s = 3'h0;
    @(posedge pclk);
    cmp_above <= v;
    repeat (30) begin
      @(posedge pclk);
      #1;
      s = s | {monitor_reset_req, irq_nonmaskable, irq_maskable};
    end
  endtask : lvl
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // watchdog against a hung handshake
  initial begin
    #500000;
    failures++;
    test_done();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, low_speed_osc, paddr, pwdata} = '0;
    cmp_above = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      chk(d, rows[i].e);
      chk({31'h0, e}, {31'h0, rows[i].a > VM2_OFS_STATUS});
    end
    apb(VM2_OFS_LEVEL, 1'b1, 32'h5);
    #1 chk({28'h0, detect_level_sel}, 32'h5);
    apb(VM2_OFS_DETCTL, 1'b1, 32'h1);
    #1 chk({31'h0, detector_enable}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      apb(VM2_OFS_CTRL1, 1'b1, 32'(k + (k == 2) * 4));
      arm(32'h0d);
      lvl(1'b0);
      chk(32'(s), (k != 0) ? ((k == 2) ? 32'h2 : 32'h1) : 32'h0);
      apb(VM2_OFS_STATUS, 1'b0, 32'h0);
      chk(d & 32'h1, 32'(k != 0));
      lvl(1'b1);
      chk(32'(s), (k != 1) ? ((k == 2) ? 32'h2 : 32'h1) : 32'h0);
    end
    arm(32'h0c);
    lvl(1'b0);
    chk(32'(s), 32'h0);
    lvl(1'b1);
    apb(VM2_OFS_STATUS, 1'b1, 32'h1);
    apb(VM2_OFS_STATUS, 1'b0, 32'h0);
    chk(d & 32'h1, 32'h1);
    apb(VM2_OFS_STATUS, 1'b1, 32'h0);
    apb(VM2_OFS_STATUS, 1'b0, 32'h0);
    chk(d & 32'h1, 32'h0);
    arm(32'hcd);
    lvl(1'b0);
    chk(32'(s), 32'h4);
    apb(VM2_OFS_CTRL0, 1'b1, 32'h4c);
    repeat (2) @(posedge pclk);
    #1 chk({31'h0, monitor_reset_req}, 32'h0);
    lvl(1'b1);
    arm(32'h4d);
    lvl(1'b0);
    @(posedge pclk);
    cmp_above <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk({31'h0, monitor_reset_req}, 32'h1);
    repeat (RH + 10) @(posedge pclk);
    #1 chk({31'h0, monitor_reset_req}, 32'h0);
    apb(VM2_OFS_CTRL0, 1'b1, 32'h08);
    for (int k = 0; k < 4; k++) begin
      apb(VM2_OFS_CTRL0, 1'b1, 32'(k << 4) | 32'h08);
      apb(VM2_OFS_CTRL0, 1'b1, 32'(k << 4));
      repeat ((2 * (2 << k) + 3) * OSC) @(posedge pclk);
      // read well inside two sample periods, so only a running filter still shows high
      cmp_above <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(VM2_OFS_STATUS, 1'b0, 32'h0);
      chk(d & 32'h2, 32'h2);
      repeat ((3 * (2 << k) + 4) * OSC) @(posedge pclk);
      apb(VM2_OFS_STATUS, 1'b0, 32'h0);
      chk(d & 32'h2, 32'h0);
      lvl(1'b1);
      repeat ((3 * (2 << k) + 4) * OSC) @(posedge pclk);
    end
    // filtered interrupt set up, then the disable order with its settling wait
    arm(32'h35);
    apb(VM2_OFS_CTRL0, 1'b1, 32'h31);
    repeat ((2 * 16 + 3) * OSC) @(posedge pclk);
    apb(VM2_OFS_CTRL0, 1'b1, 32'h30);
    apb(VM2_OFS_CTRL0, 1'b1, 32'h38);
    apb(VM2_OFS_DETCTL, 1'b1, 32'h0);
    #1 chk({31'h0, detector_enable}, 32'h0);
    apb(VM2_OFS_CTRL0, 1'b0, 32'h0);
    chk(d, 32'h38);
    // reset in mid run returns the registers to their reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({28'h0, detect_level_sel}, {28'h0, VM2_LEVEL_RST});
    presetn <= 1'b1;
    apb(VM2_OFS_CTRL0, 1'b0, 32'h0);
    chk(d, 32'h8);
    test_done();
  end
endmodule : vm2_ctrl_tb_top

bind vm2_ctrl vm2_ctrl_props vm2_ctrl_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .low_speed_osc(low_speed_osc), .cmp_above(cmp_above),
  .detector_enable(detector_enable), .detect_level_sel(detect_level_sel),
  .irq_maskable(irq_maskable), .irq_nonmaskable(irq_nonmaskable),
  .monitor_reset_req(monitor_reset_req));
